// [hdl/l1afsm_pkg.sv]
// Constants, codes and state type of the layer-1 activation controller
package l1afsm_pkg;
    // C/I commands
    localparam logic [3:0] CMD_CLK_REQ = 4'h0;
    localparam logic [3:0] CMD_L1_CLEAR = 4'h1;
    localparam logic [3:0] CMD_SINGLE_PULSE = 4'h2;
    localparam logic [3:0] CMD_CONT_PULSE = 4'h3;
    localparam logic [3:0] CMD_ACT_PRIO8 = 4'h8;
    localparam logic [3:0] CMD_ACT_PRIO10 = 4'h9;
    localparam logic [3:0] CMD_LOOP_ACT = 4'hA;
    localparam logic [3:0] CMD_DEACT = 4'hF;
    // C/I indications
    localparam logic [3:0] IND_DR = 4'h0;
    localparam logic [3:0] IND_CLEAR_ACK = 4'h1;
    localparam logic [3:0] IND_TMA = 4'h2;
    localparam logic [3:0] IND_SLD = 4'h3;
    localparam logic [3:0] IND_UNSYNC_SIG = 4'h4;
    localparam logic [3:0] IND_DR6 = 4'h5;
    localparam logic [3:0] IND_PU = 4'h7;
    localparam logic [3:0] IND_AR = 4'h8;
    localparam logic [3:0] IND_LOOP_CLOSED = 4'hA;
    localparam logic [3:0] IND_CVR = 4'hB;
    localparam logic [3:0] IND_AI8 = 4'hC;
    localparam logic [3:0] IND_AI10 = 4'hD;
    localparam logic [3:0] IND_LOOP_ACTIVE = 4'hE;
    localparam logic [3:0] IND_DEACT_CONF = 4'hF;
    // Received line info codes
    localparam logic [1:0] RX_INFO0 = 2'h0;
    localparam logic [1:0] RX_INFO2 = 2'h1;
    localparam logic [1:0] RX_INFO4 = 2'h2;
    localparam logic [1:0] RX_INFOX = 2'h3;
    // Transmitted line info codes
    localparam logic [2:0] TX_INFO0 = 3'h0;
    localparam logic [2:0] TX_INFO1 = 3'h1;
    localparam logic [2:0] TX_INFO3 = 3'h2;
    localparam logic [2:0] TX_SINGLE_PULSE = 3'h3;
    localparam logic [2:0] TX_CONT_PULSE = 3'h4;
    // Timing
    localparam int SYS_CLK_MHZ = 125;
    localparam int CLK_STOP_US = 500;
    localparam int CLK_STOP_CYC = CLK_STOP_US * SYS_CLK_MHZ;
    localparam int SINGLE_FREQ_KHZ = 2;
    localparam int CONT_FREQ_KHZ = 96;
    // One polarity flip per half period of the fundamental
    localparam int SINGLE_HALF_CYC = SYS_CLK_MHZ * 1000 / (2 * SINGLE_FREQ_KHZ);
    localparam int CONT_HALF_CYC = SYS_CLK_MHZ * 1000 / (2 * CONT_FREQ_KHZ);
    typedef enum logic [3:0] {
        ST_DEACT, ST_PEND_DEACT, ST_PWR_UP, ST_PEND_ACT, ST_UNSYNC,
        ST_SYNCED, ST_ACTIVE, ST_LOST, ST_RESET, ST_LOOP_CL, ST_LOOP_ACT,
        ST_SINGLE_PULSE, ST_CONT_PULSE
    } l1afsm_state_t;
endpackage

// [hdl/l1afsm_if.sv]
// Interface between the state machine and the test-pulse generator
`timescale 1ns/10ps
`default_nettype none
interface l1afsm_if;
    logic pulse_en;
    logic continuous;
    logic pulse_pol;
    modport ctrl (output pulse_en, output continuous, input pulse_pol);
    modport gen (input pulse_en, input continuous, output pulse_pol);
endinterface
`default_nettype wire

// [hdl/l1afsm_pulse_gen.sv]
// Alternating-polarity test pulse generator for single and continuous modes
`timescale 1ns/10ps
`default_nettype none
module l1afsm_pulse_gen
    import l1afsm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    l1afsm_if.gen pg
);
    logic [19:0] cnt_q;
    logic pol_q;
    logic [19:0] limit;

    // Half period of the fundamental for the selected mode
    assign limit = pg.continuous ? 20'(CONT_HALF_CYC - 1) : 20'(SINGLE_HALF_CYC - 1);

    // Polarity flips every half period while enabled
    always_ff @(posedge sys_clk) begin
        if (rst || !pg.pulse_en) begin
            cnt_q <= 20'h00000;
            pol_q <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 20'h00000;
            pol_q <= ~pol_q;
        end else begin
            cnt_q <= cnt_q + 20'h00001;
        end
    end
    assign pg.pulse_pol = pol_q;
endmodule
`default_nettype wire

// [hdl/l1afsm_top.sv]
// Layer-1 activation/deactivation state machine, TE side
`timescale 1ns/10ps
`default_nettype none
module l1afsm_top
    import l1afsm_pkg::*;
#(
    parameter int CLK_STOP_CYCLES = CLK_STOP_CYC
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic osc_clk,
    input wire logic [3:0] ci_cmd,
    input wire logic [1:0] rx_info,
    input wire logic rx_synced,
    input wire logic line_awake,
    input wire logic software_l1_control_bit,
    input wire logic [3:0] transceiver_command_reg,
    input wire logic clock_freeze_select,
    input wire logic tx_suppress_bit,
    input wire logic loop_internal,
    output logic osc_clock_out,
    output logic [3:0] ci_ind,
    output logic [3:0] transceiver_state_reg,
    output logic [2:0] tx_info,
    output logic tx_pulse_pol,
    output logic loop_enable,
    output logic tx_line_enable,
    output logic rx_transparent,
    output logic tx_transparent,
    output logic powerdown_flag,
    output logic clocks_stopped,
    output logic frame_synced_flag
);
    l1afsm_state_t state_q, state_d;
    logic [1:0] osc_sync_q, info_s1_q, info_s2_q, info_s3_q, info_q;
    logic [1:0] sync_sync_q, awake_sync_q;
    logic [31:0] stop_cnt_q;
    logic [3:0] cmd;
    logic [1:0] info;
    logic synced, awake;
    l1afsm_if pif();

    // Line-side inputs pass two flops before use; the received info code passes four
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            osc_sync_q <= 2'h0;
            info_s1_q <= RX_INFO0;
            info_s2_q <= RX_INFO0;
            info_s3_q <= RX_INFO0;
            info_q <= RX_INFO0;
            sync_sync_q <= 2'h0;
            awake_sync_q <= 2'h0;
        end else begin
            osc_sync_q <= {osc_sync_q[0], osc_clk};
            info_s1_q <= rx_info;
            info_s2_q <= info_s1_q;
            info_s3_q <= info_s2_q;
            // Two-bit code may skew: take it only when two samples agree
            if (info_s2_q == info_s3_q) begin
                info_q <= info_s3_q;
            end
            sync_sync_q <= {sync_sync_q[0], rx_synced};
            awake_sync_q <= {awake_sync_q[0], line_awake};
        end
    end
    assign info = info_q;
    assign synced = sync_sync_q[1];
    assign awake = awake_sync_q[1];

    // Command source: C/I channel or software register
    assign cmd = software_l1_control_bit ? transceiver_command_reg : ci_cmd;

    function automatic logic is_uncond(input logic [3:0] c);
        return (c == CMD_L1_CLEAR) || (c == CMD_LOOP_ACT) || (c == CMD_SINGLE_PULSE) || (c == CMD_CONT_PULSE);
    endfunction

    function automatic logic is_act_req(input logic [3:0] c);
        return (c == CMD_ACT_PRIO8) || (c == CMD_ACT_PRIO10);
    endfunction

    // Next-state decode
    always_comb begin
        state_d = state_q;
        if (is_uncond(cmd)) begin
            unique case (cmd)
                CMD_L1_CLEAR: state_d = ST_RESET;
                CMD_SINGLE_PULSE: state_d = ST_SINGLE_PULSE;
                CMD_CONT_PULSE: state_d = ST_CONT_PULSE;
                default: begin
                    if (state_q != ST_LOOP_ACT) begin
                        state_d = synced ? ST_LOOP_ACT : ST_LOOP_CL;
                    end
                end
            endcase
        end else begin
            unique case (state_q)
                ST_RESET, ST_SINGLE_PULSE, ST_CONT_PULSE, ST_LOOP_CL, ST_LOOP_ACT: begin
                    if (cmd == CMD_DEACT) begin
                        state_d = ST_DEACT;
                    end
                end
                ST_PEND_DEACT, ST_PWR_UP, ST_PEND_ACT, ST_UNSYNC: begin
                    if (cmd == CMD_DEACT) begin
                        state_d = ST_DEACT;
                    end else if (state_q == ST_PWR_UP && is_act_req(cmd)) begin
                        state_d = ST_PEND_ACT;
                    end else if (state_q != ST_PEND_DEACT && info == RX_INFO2 && synced) begin
                        state_d = ST_SYNCED;
                    end else if (state_q != ST_PEND_DEACT && info == RX_INFO4 && synced) begin
                        state_d = ST_ACTIVE;
                    end else if (state_q == ST_PEND_ACT && info == RX_INFOX) begin
                        state_d = ST_UNSYNC;
                    end else if (state_q == ST_UNSYNC && info == RX_INFO0) begin
                        state_d = ST_PEND_DEACT;
                    end
                end
                ST_DEACT: begin
                    if (cmd == CMD_CLK_REQ) begin
                        state_d = ST_PWR_UP;
                    end else if (is_act_req(cmd)) begin
                        state_d = ST_PEND_ACT;
                    end else if (info == RX_INFO2) begin
                        state_d = ST_SYNCED;
                    end else if (info == RX_INFO4) begin
                        state_d = ST_ACTIVE;
                    end else if (info == RX_INFOX) begin
                        state_d = ST_UNSYNC;
                    end
                end
                ST_SYNCED, ST_ACTIVE: begin
                    if (!synced) begin
                        state_d = ST_LOST;
                    end else if (info == RX_INFO0) begin
                        state_d = ST_PEND_DEACT;
                    end else if (info == RX_INFO4) begin
                        state_d = ST_ACTIVE;
                    end else if (info == RX_INFO2) begin
                        state_d = ST_SYNCED;
                    end
                end
                ST_LOST: begin
                    if (info == RX_INFO0) begin
                        state_d = ST_PEND_DEACT;
                    end else if (synced && info == RX_INFO2) begin
                        state_d = ST_SYNCED;
                    end else if (synced && info == RX_INFO4) begin
                        state_d = ST_ACTIVE;
                    end
                end
            endcase
            // Loop closes into activated once the receiver syncs
            if (state_q == ST_LOOP_CL && cmd != CMD_DEACT && synced) begin
                state_d = ST_LOOP_ACT;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Clock-stop timer in deactivated state
    always_ff @(posedge sys_clk) begin
        if (rst || state_q != ST_DEACT || info != RX_INFO0) begin
            stop_cnt_q <= 32'h00000000;
        end else if (stop_cnt_q < 32'(CLK_STOP_CYCLES)) begin
            stop_cnt_q <= stop_cnt_q + 32'h00000001;
        end
    end

    // Power-down flag and clock freeze
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            powerdown_flag <= 1'b0;
            clocks_stopped <= 1'b0;
        end else begin
            powerdown_flag <= (state_q == ST_DEACT);
            clocks_stopped <= (state_q == ST_DEACT) && !clock_freeze_select
                              && (stop_cnt_q >= 32'(CLK_STOP_CYCLES));
        end
    end

    // Buffered oscillator output, low in power-down
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            osc_clock_out <= 1'b0;
        end else begin
            osc_clock_out <= osc_sync_q[1] && !powerdown_flag;
        end
    end

    // Pulse generator control
    assign pif.pulse_en = (state_q == ST_SINGLE_PULSE) || (state_q == ST_CONT_PULSE);
    assign pif.continuous = (state_q == ST_CONT_PULSE);

    l1afsm_pulse_gen u_pulse (
        .sys_clk(sys_clk),
        .rst(rst),
        .pg(pif)
    );

    function automatic logic [3:0] ind_of(input l1afsm_state_t s, input logic aw, input logic intl);
        unique case (s)
            ST_DEACT: return IND_DEACT_CONF;
            ST_PEND_DEACT: return IND_DR;
            ST_PWR_UP: return IND_PU;
            ST_PEND_ACT: return IND_PU;
            ST_UNSYNC: return IND_UNSYNC_SIG;
            ST_SYNCED: return IND_AR;
            ST_ACTIVE: return IND_AI8;
            ST_LOST: return IND_UNSYNC_SIG;
            ST_RESET: return IND_CLEAR_ACK;
            ST_LOOP_CL: return IND_LOOP_CLOSED;
            ST_LOOP_ACT: return (intl && aw) ? IND_UNSYNC_SIG : IND_LOOP_ACTIVE;
            default: return IND_TMA;
        endcase
    endfunction

    // Line transmit, indications and data paths
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ci_ind <= IND_CLEAR_ACK;
            transceiver_state_reg <= IND_CLEAR_ACK;
            tx_info <= TX_INFO0;
            tx_pulse_pol <= 1'b0;
            loop_enable <= 1'b0;
            tx_line_enable <= 1'b0;
            rx_transparent <= 1'b0;
            tx_transparent <= 1'b0;
            frame_synced_flag <= 1'b0;
        end else begin
            ci_ind <= ind_of(state_q, awake, loop_internal);
            transceiver_state_reg <= ind_of(state_q, awake, loop_internal);
            unique case (state_q)
                ST_PEND_ACT: tx_info <= TX_INFO1;
                ST_SYNCED, ST_ACTIVE, ST_LOOP_CL, ST_LOOP_ACT: tx_info <= TX_INFO3;
                ST_SINGLE_PULSE: tx_info <= TX_SINGLE_PULSE;
                ST_CONT_PULSE: tx_info <= TX_CONT_PULSE;
                default: tx_info <= TX_INFO0;
            endcase
            tx_pulse_pol <= pif.pulse_pol;
            loop_enable <= (state_q == ST_LOOP_CL) || (state_q == ST_LOOP_ACT);
            tx_line_enable <= !(loop_enable && tx_suppress_bit && loop_internal);
            rx_transparent <= (state_q == ST_ACTIVE) || (state_q == ST_LOOP_ACT);
            frame_synced_flag <= synced;
            tx_transparent <= (state_q == ST_ACTIVE || state_q == ST_LOOP_ACT)
                              && (is_act_req(cmd) || cmd == CMD_LOOP_ACT) && synced;
        end
    end

    // Checks
    AST_DI_DEACT: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_PWR_UP && cmd == CMD_DEACT) |=> state_q == ST_DEACT)
        else $error("Deactivate command not taken");
    AST_CLKREQ_PU: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_DEACT && cmd == CMD_CLK_REQ) |=> state_q == ST_PWR_UP)
        else $error("Clock request not taken");
    AST_DEACT_IND: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_DEACT |=> ci_ind == IND_DEACT_CONF && tx_info == TX_INFO0)
        else $error("Deactivated outputs wrong");
    AST_LOST: assert property (@(posedge sys_clk) disable iff (rst)
        (state_q == ST_ACTIVE && !synced && !is_uncond(cmd)) |=> state_q == ST_LOST)
        else $error("Lost framing not entered");
    AST_UNCOND: assert property (@(posedge sys_clk) disable iff (rst)
        cmd == CMD_SINGLE_PULSE |=> state_q == ST_SINGLE_PULSE ##1 tx_info == TX_SINGLE_PULSE)
        else $error("Test command not taken");
    AST_OSC_LOW: assert property (@(posedge sys_clk) disable iff (rst)
        powerdown_flag |=> !osc_clock_out)
        else $error("Oscillator output not low");
    AST_INFO1: assert property (@(posedge sys_clk) disable iff (rst)
        state_q == ST_PEND_ACT |=> tx_info == TX_INFO1)
        else $error("INFO 1 not sent");
    AST_RX_TRANS: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(state_q == ST_ACTIVE) |=> rx_transparent)
        else $error("Receive path not transparent");
    AST_TX_TRANS: assert property (@(posedge sys_clk) disable iff (rst)
        tx_transparent |-> $past(synced))
        else $error("Transmit transparent without sync");
endmodule
`default_nettype wire

// [tb/l1afsm_nt_model.sv]
// Network-termination line model facing the transceiver
`timescale 1ns/10ps
`default_nettype none
module l1afsm_nt_model
    import l1afsm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [1:0] mode,
    input wire logic [2:0] tx_info,
    output logic [1:0] rx_info,
    output logic rx_synced
);
    initial begin
        rx_info = RX_INFO0;
        rx_synced = 1'b0;
    end
    // Mode 0 silent, 1 answers the terminal, 2 unprompted INFO 4, 3 foreign signal
    always @(posedge sys_clk) begin
        case (mode)
            2'h1: begin
                if (tx_info == TX_INFO1) begin
                    rx_info <= RX_INFO2;
                    rx_synced <= 1'b1;
                end else if (tx_info == TX_INFO3) begin
                    rx_info <= RX_INFO4;
                    rx_synced <= 1'b1;
                end
            end
            2'h2: begin
                rx_info <= RX_INFO4;
                rx_synced <= 1'b1;
            end
            2'h3: begin
                rx_info <= RX_INFOX;
                rx_synced <= 1'b0;
            end
            default: begin
                rx_info <= RX_INFO0;
                rx_synced <= 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// [tb/l1afsm_top_tb_top.sv]
// Self-checking bench for the layer-1 activation controller
`timescale 1ns/10ps
`default_nettype none
module l1afsm_top_tb_top;
    import l1afsm_pkg::*;
    localparam int STOP = 50;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic osc_clk = 1'b0;
    logic [3:0] ci_cmd = CMD_CLK_REQ;
    logic [1:0] mode = 2'h0;
    logic [1:0] rx_info;
    logic rx_synced;
    logic line_awake = 1'b0;
    logic sw_ctl = 1'b0;
    logic [3:0] sw_cmd = CMD_DEACT;
    logic freeze = 1'b1;
    logic tx_sup = 1'b0;
    logic loop_int = 1'b0;
    logic osc_clock_out, tx_pulse_pol, loop_enable, rx_transparent, tx_transparent, tx_line_enable;
    logic powerdown_flag, clocks_stopped, frame_synced_flag;
    logic [3:0] ci_ind, state_reg;
    logic [2:0] tx_info;
    int n_errors = 0;
    int n_checks = 0;
    // Clocks: system 8 ns, oscillator 160 ns
    always #4 sys_clk = ~sys_clk;
    always #80 osc_clk = ~osc_clk;
    l1afsm_nt_model nt (.sys_clk(sys_clk), .mode(mode), .tx_info(tx_info), .rx_info(rx_info),
        .rx_synced(rx_synced));
    l1afsm_top #(.CLK_STOP_CYCLES(STOP)) dut (.sys_clk(sys_clk), .rst(rst), .osc_clk(osc_clk),
        .ci_cmd(ci_cmd), .rx_info(rx_info), .rx_synced(rx_synced), .line_awake(line_awake),
        .software_l1_control_bit(sw_ctl), .transceiver_command_reg(sw_cmd),
        .clock_freeze_select(freeze), .tx_suppress_bit(tx_sup), .loop_internal(loop_int),
        .osc_clock_out(osc_clock_out), .ci_ind(ci_ind), .transceiver_state_reg(state_reg),
        .tx_info(tx_info), .tx_pulse_pol(tx_pulse_pol), .loop_enable(loop_enable),
        .tx_line_enable(tx_line_enable), .rx_transparent(rx_transparent), .tx_transparent(tx_transparent),
        .powerdown_flag(powerdown_flag), .clocks_stopped(clocks_stopped),
        .frame_synced_flag(frame_synced_flag));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", n, e, g);
        end
    endtask
    task automatic close_out();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmd(input logic [3:0] c);
        @(posedge sys_clk);
        ci_cmd <= c;
    endtask
    task automatic set_mode(input logic [1:0] m);
        @(posedge sys_clk);
        mode <= m;
    endtask
    // Bounded wait for an indication, then compare
    task automatic wait_ind(input logic [3:0] e);
        @(negedge sys_clk);
        for (int i = 0; i < 40 && ci_ind !== e; i++) @(negedge sys_clk);
        chk("ci_ind", e, ci_ind);
    endtask
    // Count oscillator output rising edges over 160 system cycles
    task automatic osc_count(output int n);
        logic p;
        n = 0;
        p = osc_clock_out;
        repeat (160) begin
            @(negedge sys_clk);
            if (osc_clock_out === 1'b1 && p === 1'b0) n++;
            p = osc_clock_out;
        end
    endtask
    // Cycles between two polarity flips of the test pulses
    task automatic half_period(input int e);
        logic p;
        int n;
        @(negedge sys_clk);
        p = tx_pulse_pol;
        for (int i = 0; i < e + 10 && tx_pulse_pol === p; i++) @(negedge sys_clk);
        p = tx_pulse_pol;
        n = 0;
        for (int i = 0; i < e + 10 && tx_pulse_pol === p; i++) begin
            @(negedge sys_clk);
            n++;
        end
        chk("pulse_half", e, n);
    endtask
    task automatic t_reset_deact();
        wait_ind(IND_CLEAR_ACK);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
        chk("tx_info", TX_INFO0, tx_info);
        chk("powerdown_flag", 1, powerdown_flag);
        chk("osc_clock_out", 0, osc_clock_out);
    endtask
    task automatic t_power_up();
        int n;
        cmd(CMD_CLK_REQ);
        wait_ind(IND_PU);
        chk("tx_info", TX_INFO0, tx_info);
        chk("powerdown_flag", 0, powerdown_flag);
        osc_count(n);
        chk("osc_run", 1, n >= 7 && n <= 9);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
    endtask
    task automatic t_activate();
        set_mode(2'h1);
        cmd(CMD_ACT_PRIO8);
        for (int i = 0; i < 40 && tx_info !== TX_INFO3; i++) @(negedge sys_clk);
        chk("tx_info", TX_INFO3, tx_info);
        wait_ind(IND_AI8);
        repeat (4) @(negedge sys_clk);
        chk("rx_transparent", 1, rx_transparent);
        chk("frame_synced_flag", 1, frame_synced_flag);
        chk("tx_transparent", 1, tx_transparent);
        set_mode(2'h3);
        repeat (10) @(negedge sys_clk);
        chk("ci_ind", IND_UNSYNC_SIG, ci_ind);
        chk("tx_transparent", 0, tx_transparent);
        chk("rx_transparent", 0, rx_transparent);
        set_mode(2'h0);
        wait_ind(IND_DR);
        repeat (10) @(negedge sys_clk);
        chk("tx_info", TX_INFO0, tx_info);
        chk("ci_ind", IND_DR, ci_ind);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
    endtask
    task automatic t_line_start();
        set_mode(2'h2);
        wait_ind(IND_AI8);
        repeat (4) @(negedge sys_clk);
        chk("tx_transparent", 0, tx_transparent);
        cmd(CMD_ACT_PRIO10);
        repeat (4) @(negedge sys_clk);
        chk("tx_transparent", 1, tx_transparent);
        set_mode(2'h0);
        wait_ind(IND_DR);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
        set_mode(2'h3);
        cmd(CMD_ACT_PRIO8);
        wait_ind(IND_UNSYNC_SIG);
        set_mode(2'h0);
        repeat (8) @(negedge sys_clk);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
    endtask
    task automatic t_loop();
        @(posedge sys_clk);
        loop_int <= 1'b1;
        tx_sup <= 1'b1;
        cmd(CMD_LOOP_ACT);
        wait_ind(IND_LOOP_CLOSED);
        chk("tx_info", TX_INFO3, tx_info);
        chk("loop_enable", 1, loop_enable);
        repeat (2) @(negedge sys_clk);
        chk("tx_line_enable", 0, tx_line_enable);
        set_mode(2'h2);
        wait_ind(IND_LOOP_ACTIVE);
        repeat (2) @(negedge sys_clk);
        chk("rx_transparent", 1, rx_transparent);
        chk("tx_transparent", 1, tx_transparent);
        @(posedge sys_clk);
        line_awake <= 1'b1;
        wait_ind(IND_UNSYNC_SIG);
        set_mode(2'h0);
        @(posedge sys_clk);
        line_awake <= 1'b0;
        repeat (8) @(negedge sys_clk);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
        @(posedge sys_clk);
        loop_int <= 1'b0;
        tx_sup <= 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("tx_line_enable", 1, tx_line_enable);
    endtask
    task automatic t_test_modes();
        cmd(CMD_CONT_PULSE);
        wait_ind(IND_TMA);
        chk("tx_info", TX_CONT_PULSE, tx_info);
        half_period(CONT_HALF_CYC);
        cmd(CMD_SINGLE_PULSE);
        repeat (3) @(negedge sys_clk);
        chk("tx_info", TX_SINGLE_PULSE, tx_info);
        wait_ind(IND_TMA);
        half_period(SINGLE_HALF_CYC);
        cmd(CMD_L1_CLEAR);
        wait_ind(IND_CLEAR_ACK);
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
    endtask
    task automatic t_software();
        @(posedge sys_clk);
        sw_cmd <= CMD_CLK_REQ;
        sw_ctl <= 1'b1;
        for (int i = 0; i < 40 && state_reg !== IND_PU; i++) @(negedge sys_clk);
        chk("state_reg", IND_PU, state_reg);
        @(posedge sys_clk);
        sw_cmd <= CMD_DEACT;
        for (int i = 0; i < 40 && state_reg !== IND_DEACT_CONF; i++) @(negedge sys_clk);
        chk("state_reg", IND_DEACT_CONF, state_reg);
        @(posedge sys_clk);
        sw_ctl <= 1'b0;
    endtask
    task automatic t_powerdown();
        int n;
        cmd(CMD_CLK_REQ);
        wait_ind(IND_PU);
        @(posedge sys_clk);
        freeze <= 1'b0;
        cmd(CMD_DEACT);
        wait_ind(IND_DEACT_CONF);
        chk("powerdown_flag", 1, powerdown_flag);
        repeat (STOP - 15) @(negedge sys_clk);
        chk("clocks_stopped", 0, clocks_stopped);
        repeat (30) @(negedge sys_clk);
        chk("clocks_stopped", 1, clocks_stopped);
        osc_count(n);
        chk("osc_edges", 0, n);
        chk("osc_clock_out", 0, osc_clock_out);
    endtask
    // Watchdog, about 90000 cycles; the pulse tests need under 70000
    initial begin
        #720000;
        n_errors++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_deact();
        t_power_up();
        t_activate();
        t_line_start();
        t_loop();
        t_software();
        t_test_modes();
        t_powerdown();
        close_out();
    end
endmodule
`default_nettype wire
